// *** tx_bitrate_seed_synth_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "tx_bitrate_seed_synth_defs.svh"

module tx_bitrate_seed_synth_regs #(
    parameter int SEED_WIDTH = 8
) (
    input  wire logic                                 clk_i,
    input  wire logic                                 rst_i,
    // Wishbone classic slave
    input  wire logic                                 cyc_i,
    input  wire logic                                 stb_i,
    input  wire logic                                 we_i,
    input  wire logic [7:2]                           adr_i,
    input  wire logic [31:0]                          dat_i,
    input  wire logic [3:0]                           sel_i,
    output logic [31:0]                               dat_o,
    output logic                                      ack_o,
    // Transmission begin from modulator logic, same clock
    input  wire logic                                 tx_begin_i,
    // Settings and timing toward the transmitter
    output tx_bitrate_seed_synth_pkg::synth_cfg_t     synth_cfg_o,
    output logic                                      symbol_tick_o,
    output logic                                      bit_clock_o,
    output logic                                      seq_bit_o,
    output logic [SEED_WIDTH-1:0]                     seq_state_o,
    output logic                                      tx_active_o
);
    ////////////////////////////////////////////////////////////////////////
    // Elaboration check: the feedback taps only serve eight bits
    generate
        if (SEED_WIDTH != 8) begin : g_bad_seed
            $error("tx_bitrate_seed_synth_regs: SEED_WIDTH must be 8");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    tx_bitrate_seed_synth_pkg::scaler_cfg_t scaler;       // Pre and post select
    logic [7:0]                             bit_rate_divider;   // Divider setting
    logic [SEED_WIDTH-1:0]                  sequence_seed;      // Start value
    logic [6:0]                             synth_integer_ch_a; // Integer offset
    logic [7:0]                             synth_fraction_ch_a_low; // Fraction low

    // Transmission state and sequence generator
    tx_bitrate_seed_synth_pkg::tx_state_t   tx_state;     // Idle or sending
    tx_bitrate_seed_synth_pkg::tx_state_t   next_tx_state;
    logic [SEED_WIDTH-1:0]                  seq_state;    // Generator shift state
    logic                                   begin_pulse;  // One-cycle start
    logic                                   stop_pulse;   // One-cycle stop

    // Divider chain results
    logic                                   bit_tick;     // One pulse per bit
    logic                                   bit_phase;    // Internal bit phase

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    // A request is served once: ack rises, then drops for one cycle
    wire logic req        = cyc_i & stb_i;
    wire logic lane0      = sel_i[0];
    // Write lands on the edge where the master sees ack high
    wire logic wr_commit  = req & we_i & ack_o & lane0;
    wire logic hit_scaler = adr_i == `IDX_CLOCK_SCALER;
    wire logic hit_div    = adr_i == `IDX_BIT_RATE_DIVIDER;
    wire logic hit_seed   = adr_i == `IDX_SEQUENCE_SEED;
    wire logic hit_int    = adr_i == `IDX_SYNTH_INTEGER_CH_A;
    wire logic hit_frac   = adr_i == `IDX_SYNTH_FRACTION_LOW;
    wire logic hit_ctrl   = adr_i == `IDX_TX_CONTROL;
    wire logic hit_status = adr_i == `IDX_TX_STATUS;

    // Control bits are commands only; they store nothing
    wire logic ctrl_begin = wr_commit & hit_ctrl & dat_i[`CTRL_BEGIN_BIT];
    wire logic ctrl_stop  = wr_commit & hit_ctrl & dat_i[`CTRL_STOP_BIT];

    // Status word: state and phase of the block itself
    wire logic [31:0] status_word = {14'h0000,
                                     seq_state,
                                     5'h00,
                                     bit_phase,
                                     tx_state == tx_bitrate_seed_synth_pkg::TX_ACTIVE,
                                     tx_state == tx_bitrate_seed_synth_pkg::TX_IDLE,
                                     2'h0};

    // Read selection; configuration registers are write-only and read zero
    wire logic [31:0] read_word = hit_status ? status_word : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Acknowledge: one cycle after the request, low for a cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            // Dropping ack after one cycle blocks double commits
            ack_o <= req & ~ack_o;
        end
    end

    // Read data captured together with ack, held while ack is high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req && !ack_o) begin
            dat_o <= we_i ? 32'h0000_0000 : read_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock scaler register: pre and post selections
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scaler.pre_sel  <= `RST_PRE_SEL;
            scaler.post_sel <= `RST_POST_SEL;
        end else if (wr_commit && hit_scaler) begin
            scaler.pre_sel  <= dat_i[`PRE_SEL_MSB:`PRE_SEL_LSB];
            scaler.post_sel <= dat_i[`POST_SEL_MSB:`POST_SEL_LSB];
        end
    end

    // Bit-rate divider: all eight bits accepted, no range clipping
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bit_rate_divider <= `RST_BIT_RATE_DIVIDER;
        end else if (wr_commit && hit_div) begin
            bit_rate_divider <= dat_i[7:0];
        end
    end

    // Sequence start value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sequence_seed <= `RST_SEQUENCE_SEED;
        end else if (wr_commit && hit_seed) begin
            sequence_seed <= dat_i[SEED_WIDTH-1:0];
        end
    end

    // Synthesizer integer offset; bit 7 of the write is dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            synth_integer_ch_a <= `RST_SYNTH_INTEGER;
        end else if (wr_commit && hit_int) begin
            synth_integer_ch_a <= dat_i[6:0];
        end
    end

    // Synthesizer fraction, low byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            synth_fraction_ch_a_low <= `RST_SYNTH_FRACTION_LOW;
        end else if (wr_commit && hit_frac) begin
            synth_fraction_ch_a_low <= dat_i[7:0];
        end
    end

    // Settings leave straight from their flip-flops
    assign synth_cfg_o.integer_ratio = synth_integer_ch_a;
    assign synth_cfg_o.fraction_low  = synth_fraction_ch_a_low;

    ////////////////////////////////////////////////////////////////////////
    // Start and stop commands, registered to one clean pulse each
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            begin_pulse <= 1'b0;
            stop_pulse  <= 1'b0;
        end else begin
            begin_pulse <= ctrl_begin | tx_begin_i;
            // Begin in the same cycle beats stop
            stop_pulse  <= ctrl_stop & ~(ctrl_begin | tx_begin_i);
        end
    end

    // Transmission state: a begin while sending restarts the frame
    always_comb begin
        next_tx_state = tx_state;
        unique case (tx_state)
            tx_bitrate_seed_synth_pkg::TX_IDLE: begin
                if (begin_pulse) begin
                    next_tx_state = tx_bitrate_seed_synth_pkg::TX_ACTIVE;
                end
            end
            tx_bitrate_seed_synth_pkg::TX_ACTIVE: begin
                if (stop_pulse) begin
                    next_tx_state = tx_bitrate_seed_synth_pkg::TX_IDLE;
                end
            end
            default: begin
                // Illegal code recovers to idle
                next_tx_state = tx_bitrate_seed_synth_pkg::TX_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_state <= tx_bitrate_seed_synth_pkg::TX_IDLE;
        end else begin
            tx_state <= next_tx_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rate chain: runs only while sending, restarts on every begin
    bit_rate_divider_chain #(
        .DIV_WIDTH (8)
    ) u_rate_chain (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .run_i     (tx_state == tx_bitrate_seed_synth_pkg::TX_ACTIVE),
        .restart_i (begin_pulse),
        .scaler_i  (scaler),
        .divider_i (bit_rate_divider),
        .bit_tick_o(bit_tick),
        .phase_o   (bit_phase)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequence generator: Galois shift, one step per bit
    // Reload wins over a step in the same cycle, so a frame always
    // starts from the programmed value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_state <= `RST_SEQUENCE_SEED;
        end else if (begin_pulse) begin
            seq_state <= sequence_seed;
        end else if (bit_tick && tx_state == tx_bitrate_seed_synth_pkg::TX_ACTIVE) begin
            seq_state <= seq_state[0] ? ((seq_state >> 1) ^ `SEQ_TAPS)
                                      : (seq_state >> 1);
        end
    end

    // Timing and sequence outputs from flip-flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            symbol_tick_o <= 1'b0;
            bit_clock_o   <= 1'b0;
            seq_bit_o     <= 1'b0;
            tx_active_o   <= 1'b0;
        end else begin
            symbol_tick_o <= bit_tick;
            bit_clock_o   <= bit_phase;
            seq_bit_o     <= seq_state[0];
            tx_active_o   <= tx_state == tx_bitrate_seed_synth_pkg::TX_ACTIVE;
        end
    end

    // Generator state is a flip-flop already
    assign seq_state_o = seq_state;

endmodule // tx_bitrate_seed_synth_regs
`default_nettype wire

// *** tx_bitrate_seed_synth_defs.svh ***
`ifndef TX_BITRATE_SEED_SYNTH_DEFS_SVH
`define TX_BITRATE_SEED_SYNTH_DEFS_SVH

// Register indices; byte address on the bus is four times the index
`define IDX_CLOCK_SCALER        6'h06
`define IDX_BIT_RATE_DIVIDER    6'h07
`define IDX_SEQUENCE_SEED       6'h08
`define IDX_SYNTH_INTEGER_CH_A  6'h09
`define IDX_SYNTH_FRACTION_LOW  6'h0a
`define IDX_TX_CONTROL          6'h20
`define IDX_TX_STATUS           6'h21

// Field positions in the clock scaler register
`define POST_SEL_MSB            5
`define POST_SEL_LSB            4
`define PRE_SEL_MSB             3
`define PRE_SEL_LSB             1

// Field positions in the control register
`define CTRL_BEGIN_BIT          0
`define CTRL_STOP_BIT           1

// Reset values
`define RST_PRE_SEL             3'h4
`define RST_POST_SEL            2'h0
`define RST_BIT_RATE_DIVIDER    8'h80
`define RST_SEQUENCE_SEED       8'hab
`define RST_SYNTH_INTEGER       7'h40
`define RST_SYNTH_FRACTION_LOW  8'h00

// Feedback taps of the sequence generator, x^8 + x^6 + x^5 + x^4 + 1
`define SEQ_TAPS                8'hb8

`endif

// *** tx_bitrate_seed_synth_pkg.sv ***
`default_nettype none
package tx_bitrate_seed_synth_pkg;

    // Synthesizer channel A settings handed to the loop
    typedef struct packed {
        logic [6:0] integer_ratio;   // Multi-modulus integer offset
        logic [7:0] fraction_low;    // Fractional ratio bits 7..0
    } synth_cfg_t;

    // Scaler selections handed to the rate divider
    typedef struct packed {
        logic [2:0] pre_sel;         // Divide by 2**code, 1..128
        logic [1:0] post_sel;        // Divide by 2**code, 1..8
    } scaler_cfg_t;

    // Transmission state, one-hot
    typedef enum logic [1:0] {
        TX_IDLE   = 2'b01,
        TX_ACTIVE = 2'b10
    } tx_state_t;

    // Terminal count of a power-of-two divider: 2**code - 1
    function automatic logic [6:0] ratio_mask(input logic [2:0] code);
        ratio_mask = 7'h7f >> (3'h7 - code);
    endfunction

endpackage
`default_nettype wire

// *** bit_rate_divider_chain.sv ***
`timescale 1ns/100ps
`default_nettype none
// Pre-scaler, programmable bit-rate counter and post-scaler in one chain.
module bit_rate_divider_chain #(
    parameter int DIV_WIDTH = 8
) (
    input  wire logic                                 clk_i,
    input  wire logic                                 rst_i,
    input  wire logic                                 run_i,
    input  wire logic                                 restart_i,
    input  wire tx_bitrate_seed_synth_pkg::scaler_cfg_t scaler_i,
    input  wire logic [DIV_WIDTH-1:0]                 divider_i,
    output logic                                      bit_tick_o,
    output logic                                      phase_o
);
    ////////////////////////////////////////////////////////////////////////
    // Elaboration check
    generate
        if (DIV_WIDTH < 1 || DIV_WIDTH > 16) begin : g_bad_width
            $error("bit_rate_divider_chain: DIV_WIDTH must be 1..16");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Counters
    logic [6:0]           pre_cnt;     // Crystal cycles inside one pre tick
    logic [DIV_WIDTH-1:0] bit_cnt;     // Pre ticks inside one half period
    logic [2:0]           post_cnt;    // Full periods inside one bit
    logic                 phase;       // Internal bit-clock phase

    // Decodes
    wire logic [6:0] pre_mask   = tx_bitrate_seed_synth_pkg::ratio_mask(scaler_i.pre_sel);
    wire logic [6:0] post_wide  = tx_bitrate_seed_synth_pkg::ratio_mask({1'b0, scaler_i.post_sel});
    wire logic [2:0] post_mask  = post_wide[2:0];
    wire logic       pre_tick   = run_i & (pre_cnt >= pre_mask);
    // Greater-or-equal so that a smaller divider written mid-count still wraps
    wire logic       bit_wrap   = pre_tick & (bit_cnt >= divider_i);
    wire logic       period_end = bit_wrap & phase;
    wire logic       post_done  = period_end & (post_cnt >= post_mask);
    wire logic       clear      = rst_i | restart_i | ~run_i;

    // Pre-scaler: divide crystal clock by 2**pre_sel
    always_ff @(posedge clk_i) begin
        if (clear || pre_tick) begin
            pre_cnt <= 7'h00;
        end else begin
            pre_cnt <= pre_cnt + 7'h01;
        end
    end

    // Counter 0..divider, then wrap and toggle phase: factor two
    always_ff @(posedge clk_i) begin
        if (clear) begin
            bit_cnt <= '0;
            phase   <= 1'b0;
        end else if (bit_wrap) begin
            bit_cnt <= '0;
            phase   <= ~phase;
        end else if (pre_tick) begin
            bit_cnt <= bit_cnt + 1'b1;
        end
    end

    // Post-scaler: count full phase periods
    always_ff @(posedge clk_i) begin
        if (clear || post_done) begin
            post_cnt <= 3'h0;
        end else if (period_end) begin
            post_cnt <= post_cnt + 3'h1;
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i) begin
        if (clear) begin
            bit_tick_o <= 1'b0;
            phase_o    <= 1'b0;
        end else begin
            bit_tick_o <= post_done;
            phase_o    <= phase;
        end
    end

endmodule // bit_rate_divider_chain
`default_nettype wire

// *** tx_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Host side: a Wishbone classic master that writes and reads the bank
module tx_host_model (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [7:2]       adr_o,
    output logic [31:0]      dat_o,
    output logic [3:0]       sel_o
);
    ////////////////////////////////////////////////////////////
    // Bus idle at time zero
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 6'h00;
        dat_o = 32'h0;
        sel_o = 4'h0;
    end

    // One single cycle; waits as long as the slave takes
    task automatic access(input logic w, input logic [7:2] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [31:0] r);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        dat_o <= d;
        sel_o <= s;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        r = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // Released we, adr and data lines show garbage, never the old value; sel keeps its value
        we_o  <= ~w;
        adr_o <= ~a;
        dat_o <= ~d;
    endtask
endmodule // tx_host_model
`default_nettype wire

// *** tx_regs_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "tx_bitrate_seed_synth_defs.svh"
// Pin-level checks; shadows mirror committed writes, so config must not move mid-frame
module tx_regs_checker #(
    parameter int SEED_WIDTH = 8
) (
    input wire logic                                   clk_i,
    input wire logic                                   rst_i,
    input wire logic                                   cyc_i,
    input wire logic                                   stb_i,
    input wire logic                                   we_i,
    input wire logic [7:2]                             adr_i,
    input wire logic [31:0]                            dat_i,
    input wire logic [3:0]                             sel_i,
    input wire logic [31:0]                            dat_o,
    input wire logic                                   ack_o,
    input wire logic                                   tx_begin_i,
    input wire tx_bitrate_seed_synth_pkg::synth_cfg_t  synth_cfg_o,
    input wire logic                                   symbol_tick_o,
    input wire logic                                   bit_clock_o,
    input wire logic                                   seq_bit_o,
    input wire logic [SEED_WIDTH-1:0]                  seq_state_o,
    input wire logic                                   tx_active_o
);
    ////////////////////////////////////////////////////////////
    wire logic commit = cyc_i && stb_i && we_i && ack_o && sel_i[0];   // Write lands
    wire logic hit_scl = commit && adr_i == `IDX_CLOCK_SCALER;
    wire logic hit_div = commit && adr_i == `IDX_BIT_RATE_DIVIDER;
    wire logic hit_seed = commit && adr_i == `IDX_SEQUENCE_SEED;
    wire logic ctl_go = commit && adr_i == `IDX_TX_CONTROL && dat_i[0];
    wire logic ctl_stop = commit && adr_i == `IDX_TX_CONTROL && dat_i[1:0] == 2'h2;
    logic [2:0] pre_q;                    // Shadow pre-divider code
    logic [1:0] post_q;                   // Shadow post-divider code
    logic [7:0] div_q;                    // Shadow divider
    logic [SEED_WIDTH-1:0] seed_q;        // Shadow start value
    logic [19:0] hcnt, tcnt;              // Cycles since last phase edge / tick
    logic hvalid, tvalid, bit_prev;       // A full span has been seen
    wire logic [19:0] half_len = (20'h1 << pre_q) * ({12'h0, div_q} + 20'h1);
    // Shift count widened so that post code 3 does not wrap to zero
    wire logic [19:0] period_len = half_len << ({1'b0, post_q} + 3'h1);
    wire logic toggle = bit_clock_o != bit_prev;

    // Shadows follow the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_q <= `RST_PRE_SEL;
            post_q <= `RST_POST_SEL;
            div_q <= `RST_BIT_RATE_DIVIDER;
            seed_q <= `RST_SEQUENCE_SEED;
        end else begin
            if (hit_scl) {post_q, pre_q} <= dat_i[5:1];
            if (hit_div) div_q <= dat_i[7:0];
            if (hit_seed) seed_q <= dat_i[SEED_WIDTH-1:0];
        end
    end

    // Span counters; first span of a frame is not judged
    always_ff @(posedge clk_i) begin
        bit_prev <= bit_clock_o;
        if (rst_i || !tx_active_o) begin
            {hcnt, tcnt, hvalid, tvalid} <= '0;
        end else begin
            hcnt <= toggle ? 20'h1 : hcnt + 20'h1;
            tcnt <= symbol_tick_o ? 20'h1 : tcnt + 20'h1;
            hvalid <= hvalid | toggle;
            tvalid <= tvalid | symbol_tick_o;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_wr(idx);
        commit && adr_i == idx;
    endsequence

    ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered next cycle");
    ack_once_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    read_zero_a: assert property (ack_o && !we_i && adr_i != `IDX_TX_STATUS |-> dat_o == 32'h0)
        else $error("write-only register read nonzero");
    int_write_a: assert property (s_wr(`IDX_SYNTH_INTEGER_CH_A) |=>
        synth_cfg_o.integer_ratio == $past(dat_i[6:0])) else $error("integer offset wrong");
    frac_write_a: assert property (s_wr(`IDX_SYNTH_FRACTION_LOW) |=>
        synth_cfg_o.fraction_low == $past(dat_i[7:0])) else $error("fraction byte wrong");
    seed_reload_a: assert property (tx_begin_i || ctl_go |-> ##2 seq_state_o == seed_q)
        else $error("generator not reloaded");
    stop_idle_a: assert property (ctl_stop |-> ##3 !tx_active_o[*2])
        else $error("stop did not idle");
    half_period_a: assert property (hvalid && toggle && tx_active_o && $past(tx_active_o)
        |-> hcnt == half_len) else $error("bit phase span wrong");
    tick_period_a: assert property (tvalid && symbol_tick_o && tx_active_o
        |-> tcnt == period_len) else $error("symbol period wrong");
    seq_bit_a: assert property (!$past(rst_i) |-> seq_bit_o == $past(seq_state_o[0]))
        else $error("sequence bit not state bit zero");
endmodule // tx_regs_checker
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "tx_bitrate_seed_synth_defs.svh"
module tb;
    ////////////////////////////////////////////////////////////
    logic clk_i = 1'b0;                   // 10 MHz
    logic rst_i = 1'b1;                   // Held for six cycles
    logic tx_begin_i = 1'b0;              // Begin pulse from modulator side
    logic cyc_i, stb_i, we_i, ack_o, symbol_tick_o, bit_clock_o, seq_bit_o, tx_active_o;
    logic [7:2] adr_i;
    logic [31:0] dat_i, dat_o, r;
    logic [3:0] sel_i;
    logic [7:0] seq_state_o, sd;
    tx_bitrate_seed_synth_pkg::synth_cfg_t synth_cfg_o;
    int n_errors = 0, n_compared = 0, seed = 79242, n, tg;
    logic last_bit;                       // Phase level at the last sample

    always #50 clk_i = ~clk_i;

    tx_host_model i_host (.clk_i(clk_i), .ack_i(ack_o), .dat_i(dat_o), .cyc_o(cyc_i),
        .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .dat_o(dat_i), .sel_o(sel_i));
    tx_bitrate_seed_synth_regs #(.SEED_WIDTH(8)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i),
        .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o), .tx_begin_i(tx_begin_i),
        .synth_cfg_o(synth_cfg_o), .symbol_tick_o(symbol_tick_o), .bit_clock_o(bit_clock_o),
        .seq_bit_o(seq_bit_o), .seq_state_o(seq_state_o), .tx_active_o(tx_active_o));

    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:2] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
        i_host.access(1'b1, a, d, s, r);
    endtask

    // Clocks per symbol: 2**pre * (div + 1) * 2 * 2**post
    function automatic int period(input int pre, input int div, input int post);
        return (1 << pre) * (div + 1) * 2 * (1 << post);
    endfunction

    // Program, start, measure one whole symbol, stop
    task automatic run_cfg(input int pre, input int post, input int div, input bit via_wr);
        sd = 8'($random(seed));
        wr(`IDX_SEQUENCE_SEED, {24'h0, sd});
        wr(`IDX_CLOCK_SCALER, {26'h0, 2'(post), 3'(pre), 1'b0});
        wr(`IDX_BIT_RATE_DIVIDER, {24'h0, 8'(div)});
        if (via_wr) begin
            wr(`IDX_TX_CONTROL, 32'h1);
        end else begin
            @(posedge clk_i) tx_begin_i <= 1'b1;
            @(posedge clk_i) tx_begin_i <= 1'b0;
        end
        @(posedge clk_i);
        #1 check("seed", {24'h0, seq_state_o}, {24'h0, sd});
        do @(posedge clk_i); while (symbol_tick_o !== 1'b1);
        n = 0;
        tg = 0;
        // Start edge count from the level standing at the tick
        last_bit = bit_clock_o;
        do begin
            @(posedge clk_i);
            n++;
            if (i_chk_toggle()) tg++;
        end while (symbol_tick_o !== 1'b1);
        check("period", 32'(n), 32'(period(pre, div, post)));
        check("phase edges", 32'(tg), 32'(2 << post));
        wr(`IDX_TX_CONTROL, 32'h2);
    endtask

    // Phase edge seen at this sample
    function automatic bit i_chk_toggle();
        i_chk_toggle = (bit_clock_o !== last_bit);
        last_bit = bit_clock_o;
    endfunction

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1 check("reset cfg", {17'h0, synth_cfg_o}, {17'h0, `RST_SYNTH_INTEGER, 8'h00});
        sd = 8'($random(seed)) | 8'h80;
        wr(`IDX_SYNTH_INTEGER_CH_A, {24'h0, sd});
        #1 check("integer", {25'h0, synth_cfg_o.integer_ratio}, {25'h0, sd[6:0]});
        wr(`IDX_SYNTH_INTEGER_CH_A, 32'h0, 4'h0);
        #1 check("masked write", {25'h0, synth_cfg_o.integer_ratio}, {25'h0, sd[6:0]});
        wr(`IDX_SYNTH_FRACTION_LOW, 32'hffff_ff5a);
        #1 check("fraction", {24'h0, synth_cfg_o.fraction_low}, 32'h5a);
        i_host.access(1'b0, `IDX_SYNTH_FRACTION_LOW, 32'h0, 4'hf, r);
        check("write-only read", r, 32'h0);
        i_host.access(1'b0, 6'h3f, 32'h0, 4'hf, r);
        check("unmapped read", r, 32'h0);
        for (int c = 0; c < 8; c++) run_cfg(c, c % 4, 0, c[0]);
        run_cfg(0, 0, 255, 1'b1);
        repeat (6) run_cfg($random(seed) & 1, $random(seed) & 1, $random(seed) & 255, 1'b0);
        // Reset in mid-frame must drop everything back
        wr(`IDX_TX_CONTROL, 32'h1);
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1 check("reset active", {31'h0, tx_active_o}, 32'h0);
        check("reset fraction", {24'h0, synth_cfg_o.fraction_low}, 32'h0);
        // Status after reset: idle, phase low, generator at its reset value
        i_host.access(1'b0, `IDX_TX_STATUS, 32'h0, 4'hf, r);
        check("status idle", r, {14'h0, `RST_SEQUENCE_SEED, 10'h004});
        close_out;
    end

    // Hang guard, well past the expected run
    initial begin
        #(80000 * 100);
        n_errors++;
        $display("FAIL watchdog expected done seen hang");
        close_out;
    end

    task automatic close_out;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
endmodule // tb

bind tx_bitrate_seed_synth_regs tx_regs_checker #(.SEED_WIDTH(SEED_WIDTH)) i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o), .tx_begin_i(tx_begin_i),
    .synth_cfg_o(synth_cfg_o), .symbol_tick_o(symbol_tick_o), .bit_clock_o(bit_clock_o),
    .seq_bit_o(seq_bit_o), .seq_state_o(seq_state_o), .tx_active_o(tx_active_o));
`default_nettype wire
